// >>> rtl/sfpi_consts.svh
// Constants of the serial flash pin interface
// Summary of operation
// RQ1: Capture instruction, address and write data on serial input at clock rise.
// RQ2: Shift read data onto serial output at clock fall for host rise sampling.
// RQ3: Lines zero and one turn bidirectional in dual and quad transfers.
// RQ4: Chip select high deselects, floats all outputs; internal operations keep running.
// RQ5: After power-up, ignore everything until chip select falls high to low.
// RQ6: Write-protect pin with protect bits blocks status writes and guards array.
// RQ7: Quad enabled turns write-protect pin into data line two.
// RQ8: Pin-function select at zero makes fourth pin the active-low hold.
// RQ9: Hold low while selected floats output, ignores clock and input.
// RQ10: Quad enable disables hold; fourth pin becomes data line three.
// RQ11: Pin-function select at one makes fourth pin an active-low reset.
// RQ12: Reset pin low about one microsecond aborts every operation in progress.
// RQ13: Hardware reset exists only with quad enable clear.
// RQ14: Four-line instruction mode moves a whole opcode in two clocks.
// RQ15: Addresses are 24 bits; continuous read skips the opcode.
// RQ16: Burst reads wrap inside aligned 8, 16, 32 or 64 byte windows.
// RQ17: Programming is by 256-byte page; array holds 4096 pages.
// RQ18: Readable 64-bit unique number and three 256-byte security regions.
// RQ19: Bidirectional lines float whenever returned data is not being driven.
`ifndef SFPI_CONSTS_SVH
`define SFPI_CONSTS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SFPI_CLK_PERIOD_NS 40
`define SFPI_T_RESET_NS    1000
`define SFPI_RESET_CYCLES  ((`SFPI_T_RESET_NS + `SFPI_CLK_PERIOD_NS - 1) / `SFPI_CLK_PERIOD_NS)
`define SFPI_RST_CNT_W     5

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define SFPI_ADDR_W        24
`define SFPI_PAGE_BYTES    256
`define SFPI_PAGE_COUNT    4096
`define SFPI_ARRAY_LOG2    20
`define SFPI_BLOCK_LOG2    16
`define SFPI_SECTOR_LOG2   12
`define SFPI_SEC_REG_LAST  2'h3
`define SFPI_UID_RESET     64'h0123456789abcdef

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SFPI_CS_SYNC_RESET 1'b0
`define SFPI_BYTE_BITS     4'h8

`endif

// >>> rtl/sfpi_pkg.sv
// Types of the serial flash pin interface
package sfpi_pkg;

  // Lane width of a transfer phase
  typedef enum logic [1:0] {
    SFPI_W1 = 2'b00,
    SFPI_W2 = 2'b01,
    SFPI_W4 = 2'b10
  } sfpi_width_t;

  // Address stepping mode
  typedef enum logic [2:0] {
    SFPI_WRAP_NONE = 3'b000,
    SFPI_WRAP_8    = 3'b001,
    SFPI_WRAP_16   = 3'b010,
    SFPI_WRAP_32   = 3'b011,
    SFPI_WRAP_64   = 3'b100,
    SFPI_WRAP_PAGE = 3'b101
  } sfpi_wrap_t;

  // Frame state
  typedef enum logic [1:0] {
    SFPI_ST_LOCKED = 2'b00,
    SFPI_ST_IDLE   = 2'b01,
    SFPI_ST_ACTIVE = 2'b10,
    SFPI_ST_HOLD   = 2'b11
  } sfpi_state_t;

endpackage

// >>> rtl/sfpi_pin_if.sv
// Pin-level front end of the serial flash
`timescale 1ns/1ns
`include "sfpi_consts.svh"

module sfpi_pin_if #(
  parameter logic [63:0] UNIQUE_ID = `SFPI_UID_RESET  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Serial pins
  input  wire logic                       sclk,
  input  wire logic                       cs_n,
  input  wire logic                       data_line_zero_in,
  output logic                            data_line_zero_out,
  output logic                            data_line_zero_oe,
  input  wire logic                       data_line_one_in,
  output logic                            data_line_one_out,
  output logic                            data_line_one_oe,
  input  wire logic                       data_line_two_in,
  output logic                            data_line_two_out,
  output logic                            data_line_two_oe,
  input  wire logic                       data_line_three_in,
  output logic                            data_line_three_out,
  output logic                            data_line_three_oe,
  // Configuration bits
  input  wire logic                       quad_enable_bit,
  input  wire logic                       pin4_function_select,
  input  wire logic                       four_line_instruction_mode,
  input  wire logic                       status_protect_bit,
  input  wire logic [2:0]                 block_protect_field,
  input  wire logic                       top_bottom_select,
  input  wire logic                       sector_granularity_select,
  input  wire logic                       complement_protect_bit,
  // Frame events
  output logic                            frame_start,
  output logic                            frame_end,
  output logic                            frame_held,
  output logic                            hw_reset_abort,
  // Receive side
  input  wire sfpi_pkg::sfpi_width_t      rx_width,
  input  wire logic                       skip_opcode,
  output logic [7:0]                      rx_byte,
  output logic                            rx_valid,
  output logic                            rx_is_opcode,
  // Transmit side
  input  wire logic                       tx_active,
  input  wire sfpi_pkg::sfpi_width_t      tx_width,
  input  wire logic [7:0]                 tx_byte,
  output logic                            tx_take,
  // Address counter
  input  wire logic                       addr_load,
  input  wire logic [`SFPI_ADDR_W-1:0]    addr_value,
  input  wire logic                       addr_step,
  input  wire sfpi_pkg::sfpi_wrap_t       addr_wrap,
  output logic [`SFPI_ADDR_W-1:0]         addr,
  // Protection and identity
  output logic                            status_write_locked,
  output logic                            addr_protected,
  output logic [1:0]                      security_region,
  output logic [7:0]                      unique_id_byte
);
  import sfpi_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [5:0]  sync_a;
  logic [5:0]  sync_b;
  logic        sclk_prev;
  logic        cs_prev;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a    <= {`SFPI_CS_SYNC_RESET, 5'h00};
      sync_b    <= {`SFPI_CS_SYNC_RESET, 5'h00};
      sclk_prev <= 1'b0;
      cs_prev   <= `SFPI_CS_SYNC_RESET;
    end else begin
      sync_a    <= {cs_n, sclk, data_line_three_in, data_line_two_in,
                    data_line_one_in, data_line_zero_in};
      sync_b    <= sync_a;
      sclk_prev <= sync_b[4];
      cs_prev   <= sync_b[5];
    end
  end

  // ------------------------------------------------------------
  // Pin function decode
  // ------------------------------------------------------------
  wire cs_s      = sync_b[5];
  wire sclk_s    = sync_b[4];
  wire line3_s   = sync_b[3];
  wire line2_s   = sync_b[2];
  wire line1_s   = sync_b[1];
  wire line0_s   = sync_b[0];
  wire cs_fall   = cs_prev & ~cs_s;
  wire sclk_rise = ~sclk_prev & sclk_s;
  wire sclk_fall = sclk_prev & ~sclk_s;
  wire wide_io   = quad_enable_bit | four_line_instruction_mode;      // see RQ7 see RQ10
  wire hold_fn   = ~wide_io & ~pin4_function_select;                  // see RQ8
  wire reset_fn  = ~wide_io & pin4_function_select;                   // see RQ11 see RQ13
  wire wp_fn     = ~wide_io;                                          // see RQ7
  wire hold_low  = hold_fn & ~line3_s & ~cs_s;                        // see RQ9
  wire reset_low = reset_fn & ~line3_s;

  // ------------------------------------------------------------
  // Hardware reset filter
  // ------------------------------------------------------------
  localparam logic [`SFPI_RST_CNT_W-1:0] RST_CYCLES = `SFPI_RST_CNT_W'(`SFPI_RESET_CYCLES);
  logic [`SFPI_RST_CNT_W-1:0] rst_cnt;
  wire rst_done = (rst_cnt == RST_CYCLES);

  always_ff @(posedge core_clk) begin
    if (rst | ~reset_low) begin
      rst_cnt <= '0;
    end else if (~rst_done) begin
      rst_cnt <= rst_cnt + 1'b1;                                      // see RQ12
    end
  end

  wire abort_now = reset_low & (rst_cnt == RST_CYCLES - 1'b1);        // see RQ12
  wire in_reset  = abort_now | rst_done;

  // ------------------------------------------------------------
  // Frame state
  // ------------------------------------------------------------
  sfpi_state_t state;
  sfpi_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      SFPI_ST_LOCKED: begin
        if (cs_fall) begin
          next_state = SFPI_ST_ACTIVE;                                // see RQ5
        end
      end
      SFPI_ST_IDLE: begin
        if (cs_fall) begin
          next_state = SFPI_ST_ACTIVE;
        end
      end
      SFPI_ST_ACTIVE: begin
        if (cs_s) begin
          next_state = SFPI_ST_IDLE;                                  // see RQ4
        end else if (hold_low) begin
          next_state = SFPI_ST_HOLD;                                  // see RQ9
        end
      end
      SFPI_ST_HOLD: begin
        if (cs_s) begin
          next_state = SFPI_ST_IDLE;
        end else if (~hold_low) begin
          next_state = SFPI_ST_ACTIVE;                                // see RQ9
        end
      end
      default: begin
        next_state = SFPI_ST_LOCKED;
      end
    endcase
    if (in_reset) begin
      next_state = SFPI_ST_LOCKED;                                    // see RQ12
    end
  end

  wire start_now = (next_state == SFPI_ST_ACTIVE) &
                   ((state == SFPI_ST_LOCKED) | (state == SFPI_ST_IDLE));
  wire end_now   = ((state == SFPI_ST_ACTIVE) | (state == SFPI_ST_HOLD)) &
                   ((next_state == SFPI_ST_IDLE) | (next_state == SFPI_ST_LOCKED));
  wire live      = (state == SFPI_ST_ACTIVE) & ~hold_low & ~cs_s & ~in_reset;
  wire rise_ok   = live & sclk_rise & ~tx_active;                     // see RQ1 see RQ9
  wire fall_ok   = live & sclk_fall & tx_active;                      // see RQ2 see RQ9

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state          <= SFPI_ST_LOCKED;
      frame_start    <= 1'b0;
      frame_end      <= 1'b0;
      hw_reset_abort <= 1'b0;
    end else begin
      state          <= next_state;
      frame_start    <= start_now;
      frame_end      <= end_now;
      hw_reset_abort <= abort_now;
    end
  end

  assign frame_held = (state == SFPI_ST_HOLD);

  // ------------------------------------------------------------
  // Receive shifter
  // ------------------------------------------------------------
  logic        first_byte;
  logic [7:0]  rx_shift;
  logic [3:0]  rx_cnt;

  wire opcode_phase = first_byte & ~skip_opcode;                      // see RQ15
  sfpi_width_t cur_rx_w;
  assign cur_rx_w = opcode_phase ?
                    (four_line_instruction_mode ? SFPI_W4 : SFPI_W1) : rx_width;  // see RQ14
  wire [3:0] rx_step = (cur_rx_w == SFPI_W4) ? 4'h4 :
                       (cur_rx_w == SFPI_W2) ? 4'h2 : 4'h1;
  wire [7:0] rx_next = (cur_rx_w == SFPI_W4) ? {rx_shift[3:0], line3_s, line2_s,
                                                line1_s, line0_s} :     // see RQ3
                       (cur_rx_w == SFPI_W2) ? {rx_shift[5:0], line1_s, line0_s} :
                       {rx_shift[6:0], line0_s};
  wire [3:0] rx_cnt_next = rx_cnt + rx_step;
  wire       rx_full     = (rx_cnt_next == `SFPI_BYTE_BITS);

  always_ff @(posedge core_clk) begin
    if (rst | start_now | in_reset) begin
      first_byte   <= 1'b1;
      rx_shift     <= 8'h00;
      rx_cnt       <= 4'h0;
      rx_valid     <= 1'b0;
      rx_is_opcode <= 1'b0;
      rx_byte      <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (rise_ok) begin
        rx_shift <= rx_next;                                          // see RQ1
        rx_cnt   <= rx_full ? 4'h0 : rx_cnt_next;
        if (rx_full) begin
          rx_byte      <= rx_next;
          rx_valid     <= 1'b1;
          rx_is_opcode <= opcode_phase;
          first_byte   <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------
  logic [7:0]  tx_shift;
  logic [3:0]  tx_cnt;
  logic [3:0]  out_bits;
  logic        tx_on;

  wire [7:0] tx_src  = (tx_cnt == 4'h0) ? tx_byte : tx_shift;
  wire [3:0] tx_step = (tx_width == SFPI_W4) ? 4'h4 :
                       (tx_width == SFPI_W2) ? 4'h2 : 4'h1;
  wire [3:0] tx_bits = (tx_width == SFPI_W4) ? tx_src[7:4] :
                       (tx_width == SFPI_W2) ? {2'b00, tx_src[7:6]} :
                       {2'b00, tx_src[7], 1'b0};
  wire [7:0] tx_rest = tx_src << tx_step;

  always_ff @(posedge core_clk) begin
    if (rst | ~tx_active | start_now | in_reset) begin
      tx_shift <= 8'h00;
      tx_cnt   <= 4'h0;
      out_bits <= 4'h0;
      tx_on    <= 1'b0;
      tx_take  <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (fall_ok) begin
        out_bits <= tx_bits;                                          // see RQ2
        tx_shift <= tx_rest;
        tx_cnt   <= (tx_cnt == 4'h0) ? (`SFPI_BYTE_BITS - tx_step) : (tx_cnt - tx_step);
        tx_take  <= (tx_cnt == 4'h0);
        tx_on    <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  wire drive  = tx_on & tx_active & live;                             // see RQ4 see RQ19
  wire lane01 = drive & (tx_width != SFPI_W1);                        // see RQ3
  wire lane23 = drive & (tx_width == SFPI_W4) & wide_io;              // see RQ7 see RQ10

  assign data_line_zero_oe   = lane01;
  assign data_line_one_oe    = drive;                                 // see RQ9
  assign data_line_two_oe    = lane23;
  assign data_line_three_oe  = lane23;
  assign data_line_zero_out  = out_bits[0];
  assign data_line_one_out   = out_bits[1];
  assign data_line_two_out   = out_bits[2];
  assign data_line_three_out = out_bits[3];

  // ------------------------------------------------------------
  // Address counter
  // ------------------------------------------------------------
  logic [`SFPI_ADDR_W-1:0] wrap_mask;

  always_comb begin
    case (addr_wrap)
      SFPI_WRAP_8:    wrap_mask = 24'h000007;                         // see RQ16
      SFPI_WRAP_16:   wrap_mask = 24'h00000f;
      SFPI_WRAP_32:   wrap_mask = 24'h00001f;
      SFPI_WRAP_64:   wrap_mask = 24'h00003f;
      SFPI_WRAP_PAGE: wrap_mask = 24'(`SFPI_PAGE_BYTES - 1);          // see RQ17
      default:        wrap_mask = 24'hffffff;
    endcase
  end

  wire [`SFPI_ADDR_W-1:0] addr_inc  = addr + 1'b1;
  wire [`SFPI_ADDR_W-1:0] addr_next = (addr & ~wrap_mask) | (addr_inc & wrap_mask);

  always_ff @(posedge core_clk) begin
    if (rst | in_reset) begin
      addr <= '0;
    end else if (addr_load) begin
      addr <= addr_value;                                             // see RQ15
    end else if (addr_step) begin
      addr <= addr_next;
    end
  end

  // ------------------------------------------------------------
  // Protection decode
  // ------------------------------------------------------------
  wire [2:0] bp_m1    = block_protect_field - 3'h1;
  wire [4:0] size_raw = (sector_granularity_select ? 5'(`SFPI_SECTOR_LOG2) :
                                                     5'(`SFPI_BLOCK_LOG2)) + {2'b00, bp_m1};
  wire [4:0] size_log = (size_raw > 5'(`SFPI_ARRAY_LOG2)) ? 5'(`SFPI_ARRAY_LOG2) : size_raw;
  wire [20:0] region  = 21'h000001 << size_log;
  wire [20:0] aoff    = {1'b0, addr[`SFPI_ARRAY_LOG2-1:0]};
  wire [20:0] top_lim = 21'(1 << `SFPI_ARRAY_LOG2) - region;
  wire in_region      = (block_protect_field != 3'h0) &
                        (top_bottom_select ? (aoff < region) : (aoff >= top_lim));  // see RQ6
  wire wp_low         = wp_fn & ~line2_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_protected      <= 1'b0;
      status_write_locked <= 1'b0;
    end else begin
      addr_protected      <= in_region ^ complement_protect_bit;      // see RQ6
      status_write_locked <= status_protect_bit & wp_low;             // see RQ6
    end
  end

  // ------------------------------------------------------------
  // Identity and security regions
  // ------------------------------------------------------------
  wire sec_hit = (addr[23:14] == 10'h000) & (addr[13:12] != 2'h0) &
                 (addr[11:8] == 4'h0) & (addr[13:12] <= `SFPI_SEC_REG_LAST);
  wire [63:0] uid_shift = UNIQUE_ID << {addr[2:0], 3'b000};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      security_region <= 2'h0;
      unique_id_byte  <= 8'h00;
    end else begin
      security_region <= sec_hit ? addr[13:12] : 2'h0;                // see RQ18
      unique_id_byte  <= uid_shift[63:56];                            // see RQ18
    end
  end

endmodule // sfpi_pin_if

// >>> verif/sfpi_host_model.sv
// Host controller model that drives the flash pins
`timescale 1ns/1ns
module sfpi_host_model (
  // Clock
  input  wire logic       core_clk,
  // Pins
  input  wire logic [3:0] line,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      drv,
  output logic [3:0]      drv_en
);
  logic [3:0] dat = 4'h0;
  logic       narrow = 1'b1;
  logic       rd = 1'b1;
  logic       wp_lvl = 1'b1;
  logic       hold_lvl = 1'b1;
  int         ln = 1;
  // Narrow modes keep protect and hold levels on lines two and three
  assign drv = {narrow ? {hold_lvl, wp_lvl} : dat[3:2], dat[1:0]};
  assign drv_en = {{2{narrow | ~rd}}, ~rd & (ln > 1), ~rd};
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
  end
  task wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task frame(input logic on);
    wait_n(8);
    cs_n = ~on;
    wait_n(8);
  endtask
  // One byte, clock idles high, data changes after each fall
  task xfer(input logic [7:0] tx, input int lanes, input logic read,
            output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    ln = lanes;
    repeat (8 / lanes) begin
      sclk = 1'b0;
      rd = read;
      if (lanes == 4) dat = sh[7:4];
      else if (lanes == 2) dat = {2'b00, sh[7:6]};
      else dat = {3'b000, sh[7]};
      sh = sh << lanes;
      wait_n(4);
      sclk = 1'b1;
      wait_n(2);
      if (lanes == 4) rx = {rx[3:0], line};
      else if (lanes == 2) rx = {rx[5:0], line[1:0]};
      else rx = {rx[6:0], line[1]};
      wait_n(2);
    end
    rd = 1'b1;
  endtask
endmodule // sfpi_host_model

// >>> verif/sfpi_pin_if_assertions.sv
// Concurrent checks on the flash pin front end ports
`timescale 1ns/1ns
module sfpi_pin_if_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_line_three_in,
  input wire logic data_line_zero_oe,
  input wire logic data_line_one_oe,
  input wire logic data_line_two_oe,
  input wire logic data_line_three_oe,
  // Configuration
  input wire logic quad_enable_bit,
  input wire logic pin4_function_select,
  input wire logic four_line_instruction_mode,
  // Events
  input wire logic frame_start,
  input wire logic frame_held,
  input wire logic hw_reset_abort,
  input wire logic rx_valid,
  input wire logic tx_active,
  input wire logic tx_take
);
  logic       any_oe;
  logic [4:0] low_cnt;
  assign any_oe = data_line_zero_oe | data_line_one_oe | data_line_two_oe | data_line_three_oe;
  // Length of the current low period of line three
  always_ff @(posedge core_clk) begin
    if (rst || data_line_three_in) low_cnt <= 5'h00;
    else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_deselect_float: assert property (cs_n [*4] |-> !any_oe)
    else $error("output driven while deselected");
  a_rx_float: assert property (!tx_active |-> !any_oe)
    else $error("output driven outside returned data");
  a_hold_float: assert property (frame_held |-> !any_oe)
    else $error("output driven while held");
  a_quad_lanes: assert property ((data_line_two_oe || data_line_three_oe) |->
    (quad_enable_bit || four_line_instruction_mode)) else $error("upper lanes driven");
  a_abort_mode: assert property (hw_reset_abort |-> pin4_function_select &&
    !quad_enable_bit && !four_line_instruction_mode) else $error("abort in wrong mode");
  a_abort_length: assert property (hw_reset_abort |-> low_cnt >= 5'h19)
    else $error("abort after short low");
  a_rx_on_rise: assert property (rx_valid |-> $past(sclk, 2))
    else $error("byte taken without clock rise");
  a_tx_on_fall: assert property (tx_take |-> !$past(sclk, 2) && $past(tx_active))
    else $error("output shift without clock fall");
  a_start_fall: assert property (frame_start |-> !cs_n && $past(cs_n, 6))
    else $error("frame without select fall");
  c_rx: cover property (rx_valid);
  c_tx: cover property (tx_take);
  c_hold: cover property (frame_held);
  c_abort: cover property (hw_reset_abort);
endmodule // sfpi_pin_if_assertions
bind sfpi_pin_if sfpi_pin_if_assertions u_chk (.*);

// >>> verif/tb_serial_flash_pin_interface.sv
// Testbench of the serial flash pin front end
`timescale 1ns/1ns
module tb_serial_flash_pin_interface;
  import sfpi_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, idle = 1'b0, last_op = 1'b0;
  logic data_line_zero_in, data_line_one_in, data_line_two_in, data_line_three_in;
  logic data_line_zero_out, data_line_one_out, data_line_two_out, data_line_three_out;
  logic data_line_zero_oe, data_line_one_oe, data_line_two_oe, data_line_three_oe;
  logic quad_enable_bit, pin4_function_select;
  logic four_line_instruction_mode, status_protect_bit;
  logic top_bottom_select = 1'b0, sector_granularity_select;
  logic complement_protect_bit, skip_opcode, tx_active;
  logic addr_load, addr_step, status_write_locked, addr_protected;
  logic frame_start, frame_end, frame_held, hw_reset_abort, rx_valid, rx_is_opcode, tx_take;
  logic [2:0] block_protect_field = 3'h1;
  logic [1:0] security_region;
  logic [7:0] rx_byte, tx_byte, unique_id_byte, last_byte = 8'h00;
  logic [23:0] addr, addr_value, rx_cnt = 24'h0, start_cnt = 24'h0, abort_cnt = 24'h0;
  logic [23:0] end_cnt = 24'h0;
  logic [3:0] line, drv, drv_en, oe, dout;
  sfpi_width_t rx_width = SFPI_W1, tx_width = SFPI_W1;
  sfpi_wrap_t addr_wrap = SFPI_WRAP_NONE;
  int bad_count = 0, total_checks = 0;
  sfpi_pin_if u_dut (.*);
  sfpi_host_model u_host (.*);
  // Released lines toggle every cycle
  assign oe = {data_line_three_oe, data_line_two_oe, data_line_one_oe, data_line_zero_oe};
  assign dout = {data_line_three_out, data_line_two_out, data_line_one_out, data_line_zero_out};
  assign line = (oe & dout) | (~oe & drv_en & drv) | (~oe & ~drv_en & {4{idle}});
  assign {data_line_three_in, data_line_two_in, data_line_one_in, data_line_zero_in} = line;
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    idle <= ~idle;
    if (rx_valid === 1'b1) begin
      rx_cnt <= rx_cnt + 24'h1;
      last_byte <= rx_byte;
      last_op <= rx_is_opcode;
    end
    if (frame_start === 1'b1) start_cnt <= start_cnt + 24'h1;
    if (frame_end === 1'b1) end_cnt <= end_cnt + 24'h1;
    if (hw_reset_abort === 1'b1) abort_cnt <= abort_cnt + 24'h1;
  end
  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task rx_chk(input logic [7:0] b, input int lanes, input logic op);
    logic [7:0] got;
    logic [23:0] n;
    n = rx_cnt;
    u_host.xfer(b, lanes, 1'b0, got);
    u_host.wait_n(4);
    check("rx_count", rx_cnt, n + 24'h1);
    check("rx_byte", {16'h0, last_byte}, {16'h0, b});
    check("rx_opcode", {23'h0, last_op}, {23'h0, op});
  endtask
  task tx_chk(input logic [7:0] b, input int lanes, input sfpi_width_t w);
    logic [7:0] got;
    tx_width = w;
    tx_byte = b;
    u_host.frame(1'b1);
    rx_chk(8'h0b, 1, 1'b1);
    tx_active = 1'b1;
    u_host.xfer(8'h00, lanes, 1'b1, got);
    tx_active = 1'b0;
    u_host.frame(1'b0);
    check("tx_data", {16'h0, got}, {16'h0, b});
  endtask
  task t_power();
    logic [7:0] got;
    u_host.xfer(8'h9f, 1, 1'b0, got);
    check("early_rx", rx_cnt, 24'h0);
    check("early_start", start_cnt, 24'h0);
    u_host.frame(1'b0);
    $display("t_power done");
  endtask
  task t_rx();
    u_host.frame(1'b1);
    check("frame_start", start_cnt, 24'h1);
    rx_width = SFPI_W2;
    rx_chk(8'ha5, 1, 1'b1);
    rx_chk(8'h3c, 2, 1'b0);
    quad_enable_bit = 1'b1;
    u_host.narrow = 1'b0;
    rx_width = SFPI_W4;
    rx_chk(8'h96, 4, 1'b0);
    u_host.frame(1'b0);
    four_line_instruction_mode = 1'b1;
    u_host.frame(1'b1);
    rx_chk(8'h5a, 4, 1'b1);
    u_host.frame(1'b0);
    four_line_instruction_mode = 1'b0;
    quad_enable_bit = 1'b0;
    u_host.narrow = 1'b1;
    $display("t_rx done");
  endtask
  task t_tx();
    tx_chk(8'hc3, 1, SFPI_W1);
    tx_chk(8'h6d, 2, SFPI_W2);
    quad_enable_bit = 1'b1;
    u_host.narrow = 1'b0;
    tx_chk(8'hb4, 4, SFPI_W4);
    quad_enable_bit = 1'b0;
    u_host.narrow = 1'b1;
    $display("t_tx done");
  endtask
  task t_hold();
    logic [7:0] got;
    logic [23:0] n;
    rx_width = SFPI_W1;
    skip_opcode = 1'b1;
    u_host.frame(1'b1);
    rx_chk(8'h03, 1, 1'b0);
    skip_opcode = 1'b0;
    u_host.hold_lvl = 1'b0;
    u_host.wait_n(6);
    check("held", {23'h0, frame_held}, 24'h1);
    n = rx_cnt;
    u_host.xfer(8'hff, 1, 1'b0, got);
    check("held_rx", rx_cnt, n);
    u_host.hold_lvl = 1'b1;
    u_host.wait_n(6);
    rx_chk(8'h42, 1, 1'b0);
    u_host.frame(1'b0);
    check("frame_end", end_cnt, 24'h6);
    $display("t_hold done");
  endtask
  task pin_low(input int n);
    u_host.hold_lvl = 1'b0;
    u_host.wait_n(n);
    u_host.hold_lvl = 1'b1;
    u_host.wait_n(6);
  endtask
  task t_reset();
    pin4_function_select = 1'b1;
    pin_low(30);
    check("abort", abort_cnt, 24'h1);
    pin_low(10);
    check("short_low", abort_cnt, 24'h1);
    quad_enable_bit = 1'b1;
    pin_low(30);
    check("quad_low", abort_cnt, 24'h1);
    quad_enable_bit = 1'b0;
    pin4_function_select = 1'b0;
    $display("t_reset done");
  endtask
  task load_step(input logic [23:0] a, input sfpi_wrap_t w, input int n);
    addr_wrap = w;
    addr_value = a;
    addr_load = 1'b1;
    u_host.wait_n(1);
    addr_load = 1'b0;
    addr_step = 1'b1;
    u_host.wait_n(n);
    addr_step = 1'b0;
    u_host.wait_n(3);
  endtask
  task t_addr();
    load_step(24'h0010fe, SFPI_WRAP_8, 2);
    check("wrap8", addr, 24'h0010f8);
    check("region", {22'h0, security_region}, 24'h1);
    check("uid", {16'h0, unique_id_byte}, 24'h1);
    load_step(24'h0002ff, SFPI_WRAP_PAGE, 1);
    check("page", addr, 24'h000200);
    check("prot_off", {23'h0, addr_protected}, 24'h0);
    {block_protect_field, sector_granularity_select, complement_protect_bit} = 5'h0b;
    u_host.wait_n(2);
    check("prot_cmp", {23'h0, addr_protected}, 24'h1);
    status_protect_bit = 1'b1;
    u_host.wp_lvl = 1'b0;
    u_host.wait_n(6);
    check("locked", {23'h0, status_write_locked}, 24'h1);
    u_host.wp_lvl = 1'b1;
    u_host.wait_n(6);
    check("unlocked", {23'h0, status_write_locked}, 24'h0);
    $display("t_addr done");
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {quad_enable_bit, pin4_function_select, four_line_instruction_mode} = 3'h0;
    {status_protect_bit, sector_granularity_select, complement_protect_bit} = 3'h0;
    {skip_opcode, tx_active, addr_load, addr_step, tx_byte, addr_value} = 36'h0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    t_power();
    t_rx();
    t_tx();
    t_hold();
    t_reset();
    t_addr();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
endmodule // tb_serial_flash_pin_interface
